// File: design/apcr_pkg.sv
// Constants, register map and control carrier of the analog power bank.
// Assumes an AXI4-Lite master with 32-bit data on one clock.
package apcr_pkg;

    // ==========================================================
    // Bus geometry and responses
    localparam int         ADDR_W      = 8;
    localparam int         IDX_W       = ADDR_W - 2;
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ==========================================================
    // Register indices, byte address is four times the index
    localparam logic [IDX_W-1:0] IDX_PAGE     = 6'h00;
    localparam logic [IDX_W-1:0] IDX_SUPPLY   = 6'h01;
    localparam logic [IDX_W-1:0] IDX_REGCTL   = 6'h02;
    localparam logic [IDX_W-1:0] IDX_LPLAY    = 6'h03;
    localparam logic [IDX_W-1:0] IDX_RPLAY    = 6'h04;
    localparam logic [IDX_W-1:0] IDX_RSVD_LO  = 6'h05;
    localparam logic [IDX_W-1:0] IDX_RSVD_HI  = 6'h08;
    localparam logic [IDX_W-1:0] IDX_OUTPWR   = 6'h09;
    localparam logic [IDX_W-1:0] IDX_INT_STAT = 6'h0A;
    localparam logic [IDX_W-1:0] IDX_INT_MASK = 6'h0B;

    // Page that this bank answers on
    localparam logic [7:0] THIS_PAGE = 8'h01;

    // ==========================================================
    // Field positions
    localparam int SC_WEAK_BIT  = 3;
    localparam int RC_VOLT_LSB  = 4;
    localparam int RC_ANA_BIT   = 3;
    localparam int RC_OC_BIT    = 1;
    localparam int RC_LDO_BIT   = 0;
    localparam int PB_CLASS_LSB = 6;
    localparam int PB_PERF_LSB  = 2;
    localparam int OP_LHP_BIT   = 5;
    localparam int OP_RHP_BIT   = 4;
    localparam int OP_LLINE_BIT = 3;
    localparam int OP_RLINE_BIT = 2;
    localparam int OP_LMIX_BIT  = 1;
    localparam int OP_RMIX_BIT  = 0;
    localparam int INT_OC_BIT   = 0;
    localparam int INT_BAD_BIT  = 1;
    localparam int INT_W        = 2;

    // ==========================================================
    // Field codes
    localparam logic [1:0] VOLT_FORBID = 2'h3;
    localparam logic [1:0] CLASS_AB    = 2'h0;
    localparam logic [1:0] CLASS_D     = 2'h3;
    localparam logic [2:0] PERF_MAX    = 3'h2;

    // ==========================================================
    // Control carrier and reset values
    typedef struct packed {
        logic [7:0] page;
        logic       weak_tie_off;
        logic [1:0] ldo_volt;
        logic       analog_off;
        logic       ldo_on;
        logic [1:0] left_class;
        logic [2:0] left_perf;
        logic [1:0] right_class;
        logic [2:0] right_perf;
        logic       left_headphone_driver;
        logic       right_headphone_driver;
        logic       left_line_driver;
        logic       right_line_driver;
        logic       left_mixer_amp;
        logic       right_mixer_amp;
    } apcr_ctrl_s;

    localparam logic [7:0]       RST_PAGE       = 8'h00;
    localparam logic             RST_ANALOG_OFF = 1'b1;
    localparam logic [INT_W-1:0] RST_INT        = 2'h0;
    localparam apcr_ctrl_s       CTRL_RST       = '{
        page:       RST_PAGE,
        analog_off: RST_ANALOG_OFF,
        default:    '0
    };

endpackage

// File: design/apcr_regs.sv
// Analog power and playback configuration register bank, AXI4-Lite slave.
// Assumes one clock, a synchronous reset and an asynchronous
// over-current level from the regulator.
//
// Design decision made here: register access over AXI4-Lite.
`timescale 1ns/10ps

module apcr_regs (
    input  wire logic                           sys_clk,
    input  wire logic                           rst,
    input  wire logic [apcr_pkg::ADDR_W-1:0]    s_axi_awaddr,
    input  wire logic                           s_axi_awvalid,
    output logic                                s_axi_awready,
    input  wire logic [31:0]                    s_axi_wdata,
    input  wire logic [3:0]                     s_axi_wstrb,
    input  wire logic                           s_axi_wvalid,
    output logic                                s_axi_wready,
    output logic [1:0]                          s_axi_bresp,
    output logic                                s_axi_bvalid,
    input  wire logic                           s_axi_bready,
    input  wire logic [apcr_pkg::ADDR_W-1:0]    s_axi_araddr,
    input  wire logic                           s_axi_arvalid,
    output logic                                s_axi_arready,
    output logic [31:0]                         s_axi_rdata,
    output logic [1:0]                          s_axi_rresp,
    output logic                                s_axi_rvalid,
    input  wire logic                           s_axi_rready,
    input  wire logic                           oc_pin,
    output apcr_pkg::apcr_ctrl_s                ctrl,
    output logic                                irq
);

    // ==========================================================
    // Declarations
    logic                               aw_full;
    logic                               w_full;
    logic [apcr_pkg::IDX_W-1:0]         aw_idx;
    logic [7:0]                         wd;
    logic                               wd_lane;
    logic                               aw_hs;
    logic                               w_hs;
    logic                               ar_hs;
    logic                               wr_go;
    logic                               wr_ok;
    logic                               wr_bad;
    logic                               page_ok;
    logic [apcr_pkg::IDX_W-1:0]         ar_idx;
    logic                               oc_meta;
    logic                               oc_level;
    logic                               oc_prev;
    logic                               oc_rise;
    logic [apcr_pkg::INT_W-1:0]         int_status;
    logic [apcr_pkg::INT_W-1:0]         int_mask;
    logic [apcr_pkg::INT_W-1:0]         next_status;
    logic [apcr_pkg::INT_W-1:0]         next_mask;

    // ==========================================================
    // Decode functions
    function automatic logic is_paged(
        input logic [apcr_pkg::IDX_W-1:0] idx
    );
        return idx >= apcr_pkg::IDX_SUPPLY &&
               idx <= apcr_pkg::IDX_OUTPWR;
    endfunction

    function automatic logic is_mapped(
        input logic [apcr_pkg::IDX_W-1:0] idx
    );
        return idx <= apcr_pkg::IDX_INT_MASK;
    endfunction

    function automatic logic bad_play(input logic [7:0] d);
        logic [1:0] cls;
        logic [2:0] prf;
        cls = d[apcr_pkg::PB_CLASS_LSB +: 2];
        prf = d[apcr_pkg::PB_PERF_LSB +: 3];
        return (cls != apcr_pkg::CLASS_AB && cls != apcr_pkg::CLASS_D) ||
               prf > apcr_pkg::PERF_MAX;
    endfunction

    function automatic logic [7:0] rd_value(
        input logic [apcr_pkg::IDX_W-1:0] idx
    );
        logic [7:0] b;
        b = 8'h00;
        if (idx == apcr_pkg::IDX_PAGE) begin
            b = ctrl.page;
        end else if (is_paged(idx) && !page_ok) begin
            b = 8'h00;
        end else begin
            case (idx)
                apcr_pkg::IDX_SUPPLY: begin
                    b[apcr_pkg::SC_WEAK_BIT] = ctrl.weak_tie_off;
                end
                apcr_pkg::IDX_REGCTL: begin
                    b[apcr_pkg::RC_VOLT_LSB +: 2] = ctrl.ldo_volt;
                    b[apcr_pkg::RC_ANA_BIT]       = ctrl.analog_off;
                    b[apcr_pkg::RC_OC_BIT]        = oc_level;
                    b[apcr_pkg::RC_LDO_BIT]       = ctrl.ldo_on;
                end
                apcr_pkg::IDX_LPLAY: begin
                    b[apcr_pkg::PB_CLASS_LSB +: 2] = ctrl.left_class;
                    b[apcr_pkg::PB_PERF_LSB +: 3]  = ctrl.left_perf;
                end
                apcr_pkg::IDX_RPLAY: begin
                    b[apcr_pkg::PB_CLASS_LSB +: 2] = ctrl.right_class;
                    b[apcr_pkg::PB_PERF_LSB +: 3]  = ctrl.right_perf;
                end
                apcr_pkg::IDX_OUTPWR: begin
                    b[apcr_pkg::OP_LHP_BIT]   = ctrl.left_headphone_driver;
                    b[apcr_pkg::OP_RHP_BIT]   = ctrl.right_headphone_driver;
                    b[apcr_pkg::OP_LLINE_BIT] = ctrl.left_line_driver;
                    b[apcr_pkg::OP_RLINE_BIT] = ctrl.right_line_driver;
                    b[apcr_pkg::OP_LMIX_BIT]  = ctrl.left_mixer_amp;
                    b[apcr_pkg::OP_RMIX_BIT]  = ctrl.right_mixer_amp;
                end
                apcr_pkg::IDX_INT_STAT: begin
                    b[apcr_pkg::INT_W-1:0] = int_status;
                end
                apcr_pkg::IDX_INT_MASK: begin
                    b[apcr_pkg::INT_W-1:0] = int_mask;
                end
                default: begin
                    b = 8'h00;
                end
            endcase
        end
        return b;
    endfunction

    // ==========================================================
    // Handshakes
    assign aw_hs   = s_axi_awvalid && s_axi_awready;
    assign w_hs    = s_axi_wvalid && s_axi_wready;
    assign ar_hs   = s_axi_arvalid && s_axi_arready;
    assign ar_idx  = s_axi_araddr[apcr_pkg::ADDR_W-1:2];
    assign wr_go   = aw_full && w_full && !s_axi_bvalid;
    assign wr_ok   = wr_go && wd_lane && is_mapped(aw_idx);
    assign page_ok = ctrl.page == apcr_pkg::THIS_PAGE;
    assign wr_bad  = wr_ok && page_ok &&
                     (((aw_idx == apcr_pkg::IDX_LPLAY ||
                        aw_idx == apcr_pkg::IDX_RPLAY) &&
                       bad_play(wd)) ||
                      (aw_idx == apcr_pkg::IDX_REGCTL &&
                       wd[apcr_pkg::RC_VOLT_LSB +: 2] ==
                       apcr_pkg::VOLT_FORBID));

    // ==========================================================
    // Write address and data channels
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            aw_full       <= 1'b0;
            aw_idx        <= '0;
            s_axi_awready <= 1'b0;
        end else begin
            if (aw_hs) begin
                aw_full       <= 1'b1;
                aw_idx        <= s_axi_awaddr[apcr_pkg::ADDR_W-1:2];
                s_axi_awready <= 1'b0;
            end else if (wr_go) begin
                aw_full <= 1'b0;
            end else if (!aw_full && !s_axi_bvalid) begin
                s_axi_awready <= 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            w_full       <= 1'b0;
            wd           <= 8'h00;
            wd_lane      <= 1'b0;
            s_axi_wready <= 1'b0;
        end else begin
            if (w_hs) begin
                w_full       <= 1'b1;
                wd           <= s_axi_wdata[7:0];
                wd_lane      <= s_axi_wstrb[0];
                s_axi_wready <= 1'b0;
            end else if (wr_go) begin
                w_full <= 1'b0;
            end else if (!w_full && !s_axi_bvalid) begin
                s_axi_wready <= 1'b1;
            end
        end
    end

    // ==========================================================
    // Write response channel
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= apcr_pkg::RESP_OKAY;
        end else begin
            if (wr_go) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= is_mapped(aw_idx) ? apcr_pkg::RESP_OKAY
                                                  : apcr_pkg::RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // ==========================================================
    // Read channels
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h00000000;
            s_axi_rresp   <= apcr_pkg::RESP_OKAY;
        end else begin
            if (ar_hs) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid  <= 1'b1;
                s_axi_rdata   <= {24'h000000, rd_value(ar_idx)};
                s_axi_rresp   <= is_mapped(ar_idx) ? apcr_pkg::RESP_OKAY
                                                   : apcr_pkg::RESP_SLVERR;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end else if (!s_axi_rvalid) begin
                s_axi_arready <= 1'b1;
            end
        end
    end

    // ==========================================================
    // Control fields
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            ctrl <= apcr_pkg::CTRL_RST;
        end else if (wr_ok && aw_idx == apcr_pkg::IDX_PAGE) begin
            ctrl.page <= wd;
        end else if (wr_ok && page_ok) begin
            case (aw_idx)
                apcr_pkg::IDX_SUPPLY: begin
                    ctrl.weak_tie_off <= wd[apcr_pkg::SC_WEAK_BIT];
                end
                apcr_pkg::IDX_REGCTL: begin
                    ctrl.ldo_volt   <= wd[apcr_pkg::RC_VOLT_LSB +: 2];
                    ctrl.analog_off <= wd[apcr_pkg::RC_ANA_BIT];
                    ctrl.ldo_on     <= wd[apcr_pkg::RC_LDO_BIT];
                end
                apcr_pkg::IDX_LPLAY: begin
                    ctrl.left_class <= wd[apcr_pkg::PB_CLASS_LSB +: 2];
                    ctrl.left_perf  <= wd[apcr_pkg::PB_PERF_LSB +: 3];
                end
                apcr_pkg::IDX_RPLAY: begin
                    ctrl.right_class <= wd[apcr_pkg::PB_CLASS_LSB +: 2];
                    ctrl.right_perf  <= wd[apcr_pkg::PB_PERF_LSB +: 3];
                end
                apcr_pkg::IDX_OUTPWR: begin
                    ctrl.left_headphone_driver  <= wd[apcr_pkg::OP_LHP_BIT];
                    ctrl.right_headphone_driver <= wd[apcr_pkg::OP_RHP_BIT];
                    ctrl.left_line_driver       <= wd[apcr_pkg::OP_LLINE_BIT];
                    ctrl.right_line_driver      <= wd[apcr_pkg::OP_RLINE_BIT];
                    ctrl.left_mixer_amp         <= wd[apcr_pkg::OP_LMIX_BIT];
                    ctrl.right_mixer_amp        <= wd[apcr_pkg::OP_RMIX_BIT];
                end
                default: begin
                    ctrl <= ctrl;
                end
            endcase
        end
    end

    // ==========================================================
    // Over-current synchroniser and edge
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            oc_meta  <= 1'b0;
            oc_level <= 1'b0;
            oc_prev  <= 1'b0;
        end else begin
            oc_meta  <= oc_pin;
            oc_level <= oc_meta;
            oc_prev  <= oc_level;
        end
    end

    assign oc_rise = oc_level && !oc_prev;

    // ==========================================================
    // Interrupt status, mask and output
    always_comb begin
        next_status = int_status;
        next_mask   = int_mask;
        if (wr_ok && aw_idx == apcr_pkg::IDX_INT_STAT) begin
            next_status = int_status & ~wd[apcr_pkg::INT_W-1:0];
        end
        if (wr_ok && aw_idx == apcr_pkg::IDX_INT_MASK) begin
            next_mask = wd[apcr_pkg::INT_W-1:0];
        end
        if (oc_rise) begin
            next_status[apcr_pkg::INT_OC_BIT] = 1'b1;
        end
        if (wr_bad) begin
            next_status[apcr_pkg::INT_BAD_BIT] = 1'b1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            int_status <= apcr_pkg::RST_INT;
            int_mask   <= apcr_pkg::RST_INT;
            irq        <= 1'b0;
        end else begin
            int_status <= next_status;
            int_mask   <= next_mask;
            irq        <= |(next_status & next_mask);
        end
    end

    // ==========================================================
    // Assertions
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);

    chk_page_gate: assert property (
        ar_hs && is_paged(ar_idx) && !page_ok
        |=> s_axi_rvalid && s_axi_rdata == 32'h00000000)
        else $error("off-page read not zero");

    chk_rsvd_zero: assert property (
        ar_hs && ar_idx >= apcr_pkg::IDX_RSVD_LO &&
        ar_idx <= apcr_pkg::IDX_RSVD_HI
        |=> s_axi_rdata == 32'h00000000 &&
            s_axi_rresp == apcr_pkg::RESP_OKAY)
        else $error("reserved location not zero");

    chk_weak_tie: assert property (
        wr_ok && page_ok && aw_idx == apcr_pkg::IDX_SUPPLY
        |=> ctrl.weak_tie_off == $past(wd[apcr_pkg::SC_WEAK_BIT]))
        else $error("weak tie bit not stored");

    chk_volt_flag: assert property (
        wr_ok && page_ok && aw_idx == apcr_pkg::IDX_REGCTL &&
        wd[apcr_pkg::RC_VOLT_LSB +: 2] == apcr_pkg::VOLT_FORBID
        |=> int_status[apcr_pkg::INT_BAD_BIT])
        else $error("forbidden voltage not flagged");

    chk_analog_rst: assert property (
        $fell(rst) |-> ctrl.analog_off && !ctrl.ldo_on)
        else $error("analog reset values wrong");

    chk_oc_status: assert property (
        ar_hs && page_ok && ar_idx == apcr_pkg::IDX_REGCTL
        |=> s_axi_rdata[apcr_pkg::RC_OC_BIT] == $past(oc_level))
        else $error("over-current status wrong");

    chk_ldo_power: assert property (
        wr_ok && page_ok && aw_idx == apcr_pkg::IDX_REGCTL
        |=> ctrl.ldo_on == $past(wd[apcr_pkg::RC_LDO_BIT]) &&
            ctrl.analog_off == $past(wd[apcr_pkg::RC_ANA_BIT]))
        else $error("regulator control not stored");

    chk_class_flag: assert property (
        wr_ok && page_ok && aw_idx == apcr_pkg::IDX_LPLAY &&
        bad_play(wd)
        |=> int_status[apcr_pkg::INT_BAD_BIT] &&
            (irq || !int_mask[apcr_pkg::INT_BAD_BIT]))
        else $error("forbidden playback code not flagged");

    chk_right_play: assert property (
        wr_ok && page_ok && aw_idx == apcr_pkg::IDX_RPLAY
        |=> ctrl.right_class == $past(wd[7:6]) &&
            ctrl.right_perf == $past(wd[4:2]))
        else $error("right playback not stored");

    chk_drivers: assert property (
        wr_ok && page_ok && aw_idx == apcr_pkg::IDX_OUTPWR
        |=> {ctrl.left_headphone_driver, ctrl.right_headphone_driver,
             ctrl.left_line_driver, ctrl.right_line_driver,
             ctrl.left_mixer_amp, ctrl.right_mixer_amp}
            == $past(wd[5:0]))
        else $error("driver power bits not stored");

    chk_ctrl_hold: assert property (
        !wr_ok |=> $stable(ctrl))
        else $error("control changed without write");

    chk_bresp_time: assert property (
        wr_go |=> s_axi_bvalid && !s_axi_awready ##1 !wr_go)
        else $error("write response late");

    cov_drv_write: cover property (
        wr_ok && page_ok && aw_idx == apcr_pkg::IDX_OUTPWR);
    cov_oc_rise: cover property (oc_rise ##1 irq);
    cov_off_page: cover property (ar_hs && !page_ok);
    cov_bad_code: cover property (wr_bad);

endmodule

// File: tb/test_apcr_regs.sv
// Self-checking bench for the analog power register bank.
// Assumes apcr_regs and apcr_pkg; the bench drives AXI4-Lite and oc_pin.
`timescale 1ns/10ps

module test_apcr_regs;
    // ==========================================================
    // Stimulus and observed signals
    logic                 sys_clk = 1'b0;
    logic                 rst     = 1'b1;
    logic [7:0]           awaddr  = 8'h00;
    logic [7:0]           araddr  = 8'h00;
    logic [31:0]          wdata   = 32'h0;
    logic [3:0]           wstrb   = 4'hF;
    logic                 awvalid = 1'b0;
    logic                 wvalid  = 1'b0;
    logic                 bready  = 1'b0;
    logic                 arvalid = 1'b0;
    logic                 rready  = 1'b0;
    logic                 oc_pin  = 1'b0;
    logic                 awready, wready, bvalid, arready, rvalid, irq;
    logic [1:0]           bresp, rresp;
    logic [31:0]          rdata;
    apcr_pkg::apcr_ctrl_s ctrl;
    int                   miscompares = 0;
    int                   checks_done = 0;

    always #5 sys_clk = ~sys_clk;

    apcr_regs u_dut (
        .sys_clk(sys_clk), .rst(rst), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .oc_pin(oc_pin), .ctrl(ctrl), .irq(irq)
    );

    // ==========================================================
    // Report and bus tasks
    task automatic test_done;
        if (miscompares == 0 && checks_done > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED at %0t: seen %h expected %h",
                     $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic [1:0] er = apcr_pkg::RESP_OKAY);
        int   n;
        logic aw_left, w_left, ha, hw;
        n       = 0;
        aw_left = 1'b1;
        w_left  = 1'b1;
        @(posedge sys_clk);
        awaddr  <= a;
        wdata   <= d;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        while ((aw_left || w_left) && n < 40) begin
            @(negedge sys_clk);
            ha = aw_left && awready === 1'b1;
            hw = w_left && wready === 1'b1;
            @(posedge sys_clk);
            if (ha) begin
                awvalid <= 1'b0;
                aw_left = 1'b0;
            end
            if (hw) begin
                wvalid <= 1'b0;
                w_left = 1'b0;
            end
            n++;
        end
        do begin
            @(negedge sys_clk);
            n++;
        end while (bvalid !== 1'b1 && n < 80);
        if (n >= 80) begin
            miscompares++;
            test_done;
        end
        chk({30'h0, bresp}, {30'h0, er});
        @(posedge sys_clk);
        bready <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp,
                      input logic [1:0] er = apcr_pkg::RESP_OKAY);
        int n;
        n = 0;
        @(posedge sys_clk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do begin
            @(negedge sys_clk);
            n++;
        end while (arready !== 1'b1 && n < 40);
        @(posedge sys_clk);
        arvalid <= 1'b0;
        do begin
            @(negedge sys_clk);
            n++;
        end while (rvalid !== 1'b1 && n < 80);
        if (n >= 80) begin
            miscompares++;
            test_done;
        end
        chk(rdata, exp);
        chk({30'h0, rresp}, {30'h0, er});
        @(posedge sys_clk);
        rready <= 1'b0;
    endtask

    task automatic chk_irq(input logic e);
        @(negedge sys_clk);
        chk({31'h0, irq}, {31'h0, e});
    endtask

    // ==========================================================
    // Scenarios
    task automatic t_reset;
        @(negedge sys_clk);
        chk(32'(ctrl), 32'(apcr_pkg::CTRL_RST));
        chk_irq(1'b0);
        rd(8'h00, 32'h00);
        wr(8'h00, 32'h01);
        rd(8'h04, 32'h00);
        rd(8'h08, 32'h08);
        rd(8'h0C, 32'h00);
        rd(8'h10, 32'h00);
        rd(8'h24, 32'h00);
    endtask

    task automatic t_fields;
        logic [7:0] d;
        for (int v = 0; v < 3; v++) begin
            wr(8'h08, {24'h0, 2'b11, 2'(v), 4'h7});
            rd(8'h08, {24'h0, 2'b00, 2'(v), 4'h1});
            chk(32'(ctrl.ldo_volt), 32'(v));
        end
        wr(8'h04, 32'hFF);
        rd(8'h04, 32'h08);
        chk(32'(ctrl.weak_tie_off), 32'h1);
        for (int c = 0; c < 4; c += 3) begin
            for (int p = 0; p < 3; p++) begin
                d = {2'(c), 1'b0, 3'(p), 2'b00};
                wr(8'h0C, {24'h0, d | 8'h23});
                wr(8'h10, {24'h0, d | 8'h23});
                rd(8'h0C, {24'h0, d});
                rd(8'h10, {24'h0, d});
                chk({ctrl.left_class, ctrl.right_perf},
                    {2'(c), 3'(p)});
            end
        end
        rd(8'h28, 32'h00);
        wr(8'h24, 32'hFF);
        rd(8'h24, 32'h3F);
        chk(32'(ctrl[5:0]), 32'h3F);
    endtask

    task automatic t_reserved;
        for (int i = 5; i < 9; i++) begin
            wr(8'(i * 4), 32'hFF);
            rd(8'(i * 4), 32'h00);
        end
    endtask

    task automatic t_page;
        wr(8'h00, 32'hFF);
        rd(8'h00, 32'hFF);
        rd(8'h24, 32'h00);
        wr(8'h24, 32'h00);
        wr(8'h00, 32'h01);
        rd(8'h24, 32'h3F);
        chk(32'(ctrl.page), 32'h01);
    endtask

    task automatic t_irq;
        wr(8'h2C, 32'h03);
        @(posedge sys_clk);
        oc_pin <= 1'b1;
        repeat (4) @(posedge sys_clk);
        rd(8'h08, 32'h23);
        rd(8'h28, 32'h01);
        chk_irq(1'b1);
        @(posedge sys_clk);
        oc_pin <= 1'b0;
        wr(8'h28, 32'h01);
        rd(8'h28, 32'h00);
        rd(8'h08, 32'h21);
        chk_irq(1'b0);
        wr(8'h08, 32'h31);
        rd(8'h28, 32'h02);
        chk_irq(1'b1);
        wr(8'h28, 32'h02);
        wr(8'h0C, 32'h40);
        rd(8'h28, 32'h02);
        wr(8'h28, 32'h02);
        wr(8'h0C, 32'h0C);
        rd(8'h28, 32'h02);
        wr(8'h28, 32'h02);
        wr(8'h10, 32'h1C);
        rd(8'h28, 32'h02);
        wr(8'h2C, 32'h00);
        chk_irq(1'b0);
        wr(8'h28, 32'h03);
    endtask

    task automatic t_errors;
        wr(8'h40, 32'hFF, apcr_pkg::RESP_SLVERR);
        rd(8'h40, 32'h00, apcr_pkg::RESP_SLVERR);
        @(posedge sys_clk);
        wstrb <= 4'h0;
        wr(8'h24, 32'h00);
        wstrb <= 4'hF;
        rd(8'h24, 32'h3F);
    endtask

    initial begin
        repeat (20) @(posedge sys_clk);
        rst <= 1'b0;
        t_reset;
        t_fields;
        t_reserved;
        t_page;
        t_irq;
        t_errors;
        test_done;
    end
endmodule
